// ---- logic/pmu_ctrl_pkg.sv ----
package pmu_ctrl_pkg;

  // ----------------------------------------------------------------
  // serial word layout
  // ----------------------------------------------------------------
  localparam int WORD_W = 29;
  localparam int NUM_CH = 4;
  localparam int RW_BIT = 28;
  localparam int CHSEL_HI = 27;
  localparam int CHSEL_LO = 24;
  localparam int FSEL_HI_BIT = 23;
  localparam int FSEL_LO_BIT = 22;

  // ----------------------------------------------------------------
  // system control field positions
  // ----------------------------------------------------------------
  localparam int CMP_DRV_HI = 17;
  localparam int CMP_DRV_LO = 14;
  localparam int CMP_POWER_BIT = 13;
  localparam int GND_PER_CH_BIT = 12;
  localparam int SHIELD_ALM_BIT = 11;
  localparam int LIMITER_ALM_BIT = 10;
  localparam int SENSE_SHORT_BIT = 9;
  localparam int GUARD_EN_BIT = 8;
  localparam int OUT_RANGE_BIT = 7;
  localparam int CUR_GAIN_BIT = 6;

  // ----------------------------------------------------------------
  // per-channel register field positions
  // ----------------------------------------------------------------
  localparam int PMU_CMP_DRV_BIT = 8;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [3:0] CMP_DRV_RST = 4'h0;
  localparam logic FIELD_BIT_RST = 1'h0;
  localparam logic [3:0] CHSEL_SYSCTL = 4'h0;
  localparam logic [28:0] WORD_ZERO = 29'h000_0000;

  typedef struct packed {
    logic [3:0] cmp_output_drive_en;
    logic cmp_power_en;
    logic ground_per_channel_sel;
    logic shield_alarm_route_en;
    logic limiter_alarm_route_en;
    logic internal_sense_short_en;
    logic guard_amp_en;
    logic output_range_sel;
    logic current_gain_sel;
  } sysctl_fields_t;

  localparam sysctl_fields_t SYSCTL_RST = '{
    cmp_output_drive_en: CMP_DRV_RST,
    cmp_power_en: FIELD_BIT_RST,
    ground_per_channel_sel: FIELD_BIT_RST,
    shield_alarm_route_en: FIELD_BIT_RST,
    limiter_alarm_route_en: FIELD_BIT_RST,
    internal_sense_short_en: FIELD_BIT_RST,
    guard_amp_en: FIELD_BIT_RST,
    output_range_sel: FIELD_BIT_RST,
    current_gain_sel: FIELD_BIT_RST
  };

endpackage : pmu_ctrl_pkg

// ---- logic/cmp_output_stage.sv ----
`timescale 1ns/1ns
module cmp_output_stage (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic drive_en_in,
  input wire logic power_en_in,
  input wire logic result_in,
  output logic pin_out,
  output logic pin_oe_out
);
  import pmu_ctrl_pkg::*;

  logic pin_d;
  logic pin_q;
  logic oe_d;
  logic oe_q;

  // comparator result only meaningful while powered
  always_comb begin
    pin_d = result_in & power_en_in;
    oe_d = drive_en_in;
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      pin_q <= FIELD_BIT_RST;
      oe_q <= FIELD_BIT_RST;
    end else begin
      pin_q <= pin_d;
      oe_q <= oe_d;
    end
  end

  assign pin_out = pin_q;
  assign pin_oe_out = oe_q;

endmodule : cmp_output_stage

// ---- logic/pmu_system_control_fields.sv ----
`timescale 1ns/1ns
// Behaviour
// - each set output enable bit lets that channel drive its comparator output
// - comparators work only while power bit 13 set; software sets it first
// - comparator power resets to zero; one powers all, zero shuts down
// - output enables are one shared set written from either register
// - readback from either register returns the latest shared enable value
// - ground-per-channel bit makes shared pin a test ground, guard tied to sense
// - ground-per-channel bit clear at power-on, pin acts as guard input
// - alarm pin off by default; guard and clamp bits each route their source
// - sense short bit closes sense short switch and ground tie switch
// - guard amplifier enable resets zero; one enables guard amplifiers
// - output range bit: zero unity bipolar, one gain 0.2 unipolar
// - current gain bit: zero gain ten, one gain five
// - comparator outputs high-impedance from power-on until enabled
// - system control addressed only with function and channel selects zero
module pmu_system_control_fields (
  input wire logic MCLK_IN,
  input wire logic RST_IN,
  input wire logic [pmu_ctrl_pkg::WORD_W-1:0] WORD_IN,
  input wire logic WORD_VALID_IN,
  input wire logic [pmu_ctrl_pkg::NUM_CH-1:0] CMP_RESULT_IN,
  input wire logic SHIELD_ALARM_IN,
  input wire logic LIMITER_ALARM_IN,
  output logic [pmu_ctrl_pkg::NUM_CH-1:0] CMP_OUT,
  output logic [pmu_ctrl_pkg::NUM_CH-1:0] CMP_OE_OUT,
  output logic CMP_POWER_EN_OUT,
  output logic GROUND_PER_CHANNEL_SEL_OUT,
  output logic SHIELD_TO_SENSE_TIE_OUT,
  output logic SHARED_ALARM_PIN_OUT,
  output logic SHARED_ALARM_PIN_OE_OUT,
  output logic SENSE_SHORT_SWITCH_OUT,
  output logic GROUND_TIE_SWITCH_OUT,
  output logic GUARD_AMP_EN_OUT,
  output logic OUTPUT_RANGE_SEL_OUT,
  output logic CURRENT_GAIN_SEL_OUT,
  output logic [pmu_ctrl_pkg::WORD_W-1:0] READ_DATA_OUT,
  output logic READ_VALID_OUT
);
  import pmu_ctrl_pkg::*;

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  function automatic logic fsel_zero(input logic [WORD_W-1:0] w);
    fsel_zero = !w[FSEL_HI_BIT] && !w[FSEL_LO_BIT];
  endfunction : fsel_zero

  function automatic logic is_sysctl(input logic [WORD_W-1:0] w);
    is_sysctl = fsel_zero(w) && (w[CHSEL_HI:CHSEL_LO] == CHSEL_SYSCTL);
  endfunction : is_sysctl

  function automatic logic is_pmu(input logic [WORD_W-1:0] w);
    is_pmu = fsel_zero(w) && (w[CHSEL_HI:CHSEL_LO] != CHSEL_SYSCTL);
  endfunction : is_pmu

  logic rd;
  logic wr;
  logic [NUM_CH-1:0] ch_mask;

  always_comb begin
    rd = WORD_VALID_IN && WORD_IN[RW_BIT];
    wr = WORD_VALID_IN && !WORD_IN[RW_BIT];
    ch_mask = WORD_IN[CHSEL_HI:CHSEL_LO];
  end

  // ----------------------------------------------------------------
  // field storage
  // ----------------------------------------------------------------
  sysctl_fields_t fields_d;
  sysctl_fields_t fields_q;

  always_comb begin
    fields_d = fields_q;
    if (wr && is_sysctl(WORD_IN)) begin
      fields_d.cmp_output_drive_en = WORD_IN[CMP_DRV_HI:CMP_DRV_LO];
      fields_d.cmp_power_en = WORD_IN[CMP_POWER_BIT];
      fields_d.ground_per_channel_sel = WORD_IN[GND_PER_CH_BIT];
      fields_d.shield_alarm_route_en = WORD_IN[SHIELD_ALM_BIT];
      fields_d.limiter_alarm_route_en = WORD_IN[LIMITER_ALM_BIT];
      fields_d.internal_sense_short_en = WORD_IN[SENSE_SHORT_BIT];
      fields_d.guard_amp_en = WORD_IN[GUARD_EN_BIT];
      fields_d.output_range_sel = WORD_IN[OUT_RANGE_BIT];
      fields_d.current_gain_sel = WORD_IN[CUR_GAIN_BIT];
    end else if (wr && is_pmu(WORD_IN)) begin
      // broadcast: every selected channel takes the same enable
      for (int i = 0; i < NUM_CH; i++) begin
        if (ch_mask[i]) begin
          fields_d.cmp_output_drive_en[i] = WORD_IN[PMU_CMP_DRV_BIT];
        end
      end
    end
  end

  always_ff @(posedge MCLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      fields_q <= SYSCTL_RST;
    end else begin
      fields_q <= fields_d;
    end
  end

  // ----------------------------------------------------------------
  // readback
  // ----------------------------------------------------------------
  logic [WORD_W-1:0] rdata_d;
  logic [WORD_W-1:0] rdata_q;
  logic rvalid_d;
  logic rvalid_q;
  logic ch_bit;

  // lowest selected channel answers a per-channel read
  always_comb begin
    ch_bit = FIELD_BIT_RST;
    for (int i = NUM_CH - 1; i >= 0; i--) begin
      if (ch_mask[i]) begin
        ch_bit = fields_q.cmp_output_drive_en[i];
      end
    end
  end

  always_comb begin
    rdata_d = rdata_q;
    rvalid_d = 1'h0;
    if (rd && is_sysctl(WORD_IN)) begin
      rdata_d = WORD_ZERO;
      rdata_d[CMP_DRV_HI:CMP_DRV_LO] = fields_q.cmp_output_drive_en;
      rdata_d[CMP_POWER_BIT] = fields_q.cmp_power_en;
      rdata_d[GND_PER_CH_BIT] = fields_q.ground_per_channel_sel;
      rdata_d[SHIELD_ALM_BIT] = fields_q.shield_alarm_route_en;
      rdata_d[LIMITER_ALM_BIT] = fields_q.limiter_alarm_route_en;
      rdata_d[SENSE_SHORT_BIT] = fields_q.internal_sense_short_en;
      rdata_d[GUARD_EN_BIT] = fields_q.guard_amp_en;
      rdata_d[OUT_RANGE_BIT] = fields_q.output_range_sel;
      rdata_d[CUR_GAIN_BIT] = fields_q.current_gain_sel;
      rvalid_d = 1'h1;
    end else if (rd && is_pmu(WORD_IN)) begin
      rdata_d = WORD_ZERO;
      rdata_d[PMU_CMP_DRV_BIT] = ch_bit;
      rvalid_d = 1'h1;
    end
  end

  always_ff @(posedge MCLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      rdata_q <= WORD_ZERO;
      rvalid_q <= FIELD_BIT_RST;
    end else begin
      rdata_q <= rdata_d;
      rvalid_q <= rvalid_d;
    end
  end

  // ----------------------------------------------------------------
  // control outputs
  // ----------------------------------------------------------------
  sysctl_fields_t out_d;
  sysctl_fields_t out_q;

  always_comb begin
    out_d = fields_q;
  end

  always_ff @(posedge MCLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      out_q <= SYSCTL_RST;
    end else begin
      out_q <= out_d;
    end
  end

  // ----------------------------------------------------------------
  // shared alarm pin
  // ----------------------------------------------------------------
  logic alarm_oe_d;
  logic alarm_oe_q;
  logic alarm_pin_d;
  logic alarm_pin_q;

  // open drain: data held low, enable pulls the line
  always_comb begin
    alarm_pin_d = FIELD_BIT_RST;
    alarm_oe_d = (SHIELD_ALARM_IN && fields_q.shield_alarm_route_en) ||
                 (LIMITER_ALARM_IN && fields_q.limiter_alarm_route_en);
  end

  always_ff @(posedge MCLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      alarm_pin_q <= FIELD_BIT_RST;
      alarm_oe_q <= FIELD_BIT_RST;
    end else begin
      alarm_pin_q <= alarm_pin_d;
      alarm_oe_q <= alarm_oe_d;
    end
  end

  assign SHARED_ALARM_PIN_OUT = alarm_pin_q;
  assign SHARED_ALARM_PIN_OE_OUT = alarm_oe_q;
  assign CMP_POWER_EN_OUT = out_q.cmp_power_en;
  assign GROUND_PER_CHANNEL_SEL_OUT = out_q.ground_per_channel_sel;
  assign SHIELD_TO_SENSE_TIE_OUT = out_q.ground_per_channel_sel;
  assign SENSE_SHORT_SWITCH_OUT = out_q.internal_sense_short_en;
  assign GROUND_TIE_SWITCH_OUT = out_q.internal_sense_short_en;
  assign GUARD_AMP_EN_OUT = out_q.guard_amp_en;
  assign OUTPUT_RANGE_SEL_OUT = out_q.output_range_sel;
  assign CURRENT_GAIN_SEL_OUT = out_q.current_gain_sel;
  assign READ_DATA_OUT = rdata_q;
  assign READ_VALID_OUT = rvalid_q;

  // ----------------------------------------------------------------
  // comparator output stages
  // ----------------------------------------------------------------
  for (genvar g = 0; g < NUM_CH; g++) begin : g_cmp
    cmp_output_stage u_stage (
      .clk_in(MCLK_IN),
      .rst_in(RST_IN),
      .drive_en_in(fields_q.cmp_output_drive_en[g]),
      .power_en_in(fields_q.cmp_power_en),
      .result_in(CMP_RESULT_IN[g]),
      .pin_out(CMP_OUT[g]),
      .pin_oe_out(CMP_OE_OUT[g])
    );
  end

endmodule : pmu_system_control_fields

// ---- bench/pmu_ctrl_asserts.sv ----
`timescale 1ns/1ns
module pmu_ctrl_asserts (
  input wire logic MCLK_IN,
  input wire logic RST_IN,
  input wire logic [28:0] WORD_IN,
  input wire logic WORD_VALID_IN,
  input wire logic SHIELD_ALARM_IN,
  input wire logic LIMITER_ALARM_IN,
  input wire logic [3:0] CMP_OUT,
  input wire logic [3:0] CMP_OE_OUT,
  input wire logic CMP_POWER_EN_OUT,
  input wire logic GROUND_PER_CHANNEL_SEL_OUT,
  input wire logic SHIELD_TO_SENSE_TIE_OUT,
  input wire logic SHARED_ALARM_PIN_OUT,
  input wire logic SHARED_ALARM_PIN_OE_OUT,
  input wire logic SENSE_SHORT_SWITCH_OUT,
  input wire logic GROUND_TIE_SWITCH_OUT,
  input wire logic GUARD_AMP_EN_OUT,
  input wire logic OUTPUT_RANGE_SEL_OUT,
  input wire logic CURRENT_GAIN_SEL_OUT,
  input wire logic READ_VALID_OUT
);
  default clocking cb @(posedge MCLK_IN); endclocking
  default disable iff (RST_IN);
  sequence wr_sys;
    WORD_VALID_IN && !WORD_IN[28] && WORD_IN[27:22] == 6'h00;
  endsequence
  sequence rd_any;
    WORD_VALID_IN && WORD_IN[28] && WORD_IN[23:22] == 2'h0;
  endsequence
  oe_write_a: assert property (wr_sys |-> ##2 CMP_OE_OUT == $past(WORD_IN[17:14], 2))
    else $error("output enables wrong");
  power_write_a: assert property (wr_sys |-> ##2 CMP_POWER_EN_OUT == $past(WORD_IN[13], 2))
    else $error("power bit wrong");
  gnd_write_a: assert property (wr_sys |-> ##2 GROUND_PER_CHANNEL_SEL_OUT == $past(WORD_IN[12], 2))
    else $error("ground select wrong");
  tie_follow_a: assert property (SHIELD_TO_SENSE_TIE_OUT == GROUND_PER_CHANNEL_SEL_OUT)
    else $error("tie differs");
  short_write_a: assert property (wr_sys |-> ##2 {SENSE_SHORT_SWITCH_OUT, GROUND_TIE_SWITCH_OUT} == {2{$past(WORD_IN[9], 2)}})
    else $error("short switches wrong");
  amp_gain_a: assert property (wr_sys |-> ##2 {GUARD_AMP_EN_OUT, OUTPUT_RANGE_SEL_OUT, CURRENT_GAIN_SEL_OUT} == $past(WORD_IN[8:6], 2))
    else $error("guard or gain wrong");
  alarm_quiet_a: assert property (!$past(SHIELD_ALARM_IN) && !$past(LIMITER_ALARM_IN) |-> !SHARED_ALARM_PIN_OE_OUT && !SHARED_ALARM_PIN_OUT)
    else $error("alarm without source");
  cmp_off_a: assert property (!CMP_POWER_EN_OUT && !$past(CMP_POWER_EN_OUT) |-> CMP_OUT == 4'h0)
    else $error("comparator active unpowered");
  read_answer_a: assert property (rd_any |-> ##[1:2] READ_VALID_OUT)
    else $error("read not answered");
  read_idle_a: assert property (!$past(WORD_VALID_IN) && !$past(WORD_VALID_IN, 2) |-> !READ_VALID_OUT)
    else $error("spurious read valid");
endmodule : pmu_ctrl_asserts
bind pmu_system_control_fields pmu_ctrl_asserts chk (.*);

// ---- bench/tb.sv ----
`timescale 1ns/1ns
module tb;
  import pmu_ctrl_pkg::*;
  logic MCLK_IN = 0, RST_IN = 1, WORD_VALID_IN = 0, SHIELD_ALARM_IN = 0, LIMITER_ALARM_IN = 0;
  logic [28:0] WORD_IN = '0, READ_DATA_OUT, d;
  logic [3:0] CMP_RESULT_IN = '0, CMP_OUT, CMP_OE_OUT;
  logic CMP_POWER_EN_OUT, GROUND_PER_CHANNEL_SEL_OUT, SHIELD_TO_SENSE_TIE_OUT, SHARED_ALARM_PIN_OUT;
  logic SHARED_ALARM_PIN_OE_OUT, SENSE_SHORT_SWITCH_OUT, GROUND_TIE_SWITCH_OUT, GUARD_AMP_EN_OUT;
  logic OUTPUT_RANGE_SEL_OUT, CURRENT_GAIN_SEL_OUT, READ_VALID_OUT;
  int failures = 0, checks_done = 0;
  pmu_system_control_fields uut (.*);
  initial forever #4 MCLK_IN = ~MCLK_IN;
  function automatic logic [28:0] sysw(logic [11:0] v);
    return {11'h000, v, 6'h00};
  endfunction : sysw
  function automatic logic [28:0] chw(logic r, logic [3:0] sel, logic en);
    return {r, sel, 15'h0000, en, 8'h00};
  endfunction : chw
  task chk(input string what, input logic [28:0] seen, input logic [28:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task send(input logic [28:0] w);
    @(posedge MCLK_IN) #1;
    WORD_IN = w;
    WORD_VALID_IN = 1;
    @(posedge MCLK_IN) #1;
    WORD_VALID_IN = 0;
  endtask : send
  task wr(input logic [28:0] w);
    send(w);
    repeat (2) @(posedge MCLK_IN);
    #1;
  endtask : wr
  task rd(input logic [28:0] w);
    int i;
    send(w);
    for (i = 0; i < 4 && READ_VALID_OUT !== 1'h1; i++) @(posedge MCLK_IN) #1;
    chk("read_valid", READ_VALID_OUT, 1);
    d = READ_DATA_OUT;
  endtask : rd
  task t_reset();
    chk("oe_reset", CMP_OE_OUT, 0);
    chk("power_reset", CMP_POWER_EN_OUT, 0);
    chk("gnd_reset", GROUND_PER_CHANNEL_SEL_OUT, 0);
    chk("guard_reset", GUARD_AMP_EN_OUT, 0);
    SHIELD_ALARM_IN = 1;
    LIMITER_ALARM_IN = 1;
    repeat (2) @(posedge MCLK_IN) #1;
    chk("alarm_reset", SHARED_ALARM_PIN_OE_OUT, 0);
  endtask : t_reset
  task t_fields();
    logic [11:0] v;
    for (int b = 0; b < 12; b++) begin
      v = 12'h001 << b;
      wr(sysw(v));
      chk("fields", {CMP_OE_OUT, CMP_POWER_EN_OUT, GROUND_PER_CHANNEL_SEL_OUT, 2'h0, SENSE_SHORT_SWITCH_OUT,
        GUARD_AMP_EN_OUT, OUTPUT_RANGE_SEL_OUT, CURRENT_GAIN_SEL_OUT}, v & 12'hFCF);
      chk("ties", {SHIELD_TO_SENSE_TIE_OUT, GROUND_TIE_SWITCH_OUT}, {v[6], v[3]});
      rd(chw(1, 4'h0, 0));
      chk("sys_read", d, sysw(v));
    end
  endtask : t_fields
  task t_shared();
    wr(sysw(12'h5AA));
    wr(chw(0, 4'hA, 1));
    chk("oe_merge", CMP_OE_OUT, 4'hF);
    wr(chw(0, 4'h1, 0));
    chk("oe_clear", CMP_OE_OUT, 4'hE);
    rd(chw(1, 4'h0, 0));
    chk("sys_oe_read", d, sysw(12'hEAA));
    rd(chw(1, 4'h2, 0));
    chk("ch_oe_read", d, chw(0, 4'h0, 1));
  endtask : t_shared
  task t_alarm();
    for (int i = 0; i < 16; i++) begin
      wr(sysw({6'h00, i[1:0], 4'h0}));
      SHIELD_ALARM_IN = i[3];
      LIMITER_ALARM_IN = i[2];
      repeat (2) @(posedge MCLK_IN) #1;
      chk("alarm_oe", SHARED_ALARM_PIN_OE_OUT, (i[3] & i[1]) | (i[2] & i[0]));
      chk("alarm_data", SHARED_ALARM_PIN_OUT, 0);
    end
  endtask : t_alarm
  task t_cmp();
    for (int p = 0; p < 2; p++) begin
      wr(sysw({4'hF, p[0], 7'h00}));
      CMP_RESULT_IN = 4'hA;
      repeat (2) @(posedge MCLK_IN) #1;
      chk("cmp_out", CMP_OUT, p ? 4'hA : 4'h0);
    end
  endtask : t_cmp
  task t_refused();
    wr(sysw(12'h000));
    wr(sysw(12'hFFF) | 29'h0040_0000);
    chk("refused_oe", CMP_OE_OUT, 0);
    chk("refused_pwr", CMP_POWER_EN_OUT, 0);
  endtask : t_refused
  task tally_and_finish();
    if (failures == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : tally_and_finish
  initial begin
    #100000;
    failures++;
    tally_and_finish();
  end
  initial begin
    repeat (3) @(posedge MCLK_IN);
    #1;
    RST_IN = 0;
    t_reset();
    t_fields();
    t_shared();
    t_alarm();
    t_cmp();
    t_refused();
    tally_and_finish();
  end
endmodule : tb
